// >>> port_power_overcurrent_ctl.sv
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ns
module port_power_overcurrent_ctl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  output logic irq,
  input wire logic [5:0] port_power_sense_pin_in,
  output logic [5:0] port_power_sense_pin_out,
  output logic [5:0] port_power_sense_pin_oe_n,
  output logic [5:0] port_power_sense_pull_up,
  input wire logic [5:0] superspeed_power_sense_pin_in,
  output logic [5:0] superspeed_power_sense_pin_out,
  output logic [5:0] superspeed_power_sense_pin_oe_n,
  output logic [5:0] superspeed_power_sense_pull_up,
  output logic [5:0] hs_power_on,
  output logic [5:0] ss_power_on,
  output logic [5:0] hs_overcurrent,
  output logic [5:0] ss_overcurrent,
  input wire logic [7:0] cc_compare_in,
  output logic [2:0] cc_threshold_sel,
  output logic [1:0] vconn_enable,
  input wire logic [1:0] vconn_in_range,
  input wire logic bus_voltage_monitor_input_safe5v,
  input wire logic bus_voltage_monitor_input_safe0v,
  output logic vbus_attached
);
  logic [5:0] power;
  logic [5:0] split;
  logic [5:0] ss_power;
  logic [5:0] charge;
  logic [15:0] filter_len;
  logic [ppoc_pkg::ST_W-1:0] status;
  logic [ppoc_pkg::ST_W-1:0] mask;
  logic [ppoc_pkg::ST_W-1:0] events;
  logic ufp_mode;
  logic [1:0] vconn_req;
  logic [5:0] pin_s;
  logic [5:0] ss_pin_s;
  logic [5:0] fault;
  logic [5:0] ss_fault;
  logic [5:0] fault_d;
  logic [5:0] ss_fault_d;
  logic [7:0] cc_s;
  logic [7:0] cc_d;
  logic [1:0] vin_s;
  logic safe5_s;
  logic safe0_s;
  logic safe5_d;
  logic [5:0] ss_eff;
  logic [5:0] pin_rel1;
  logic [5:0] pin_rel2;
  logic [5:0] ss_rel1;
  logic [5:0] ss_rel2;
  typedef enum logic [0:0] {
    VBUS_DETACHED = 1'b0,
    VBUS_ATTACHED = 1'b1
  } vbus_state_t;
  vbus_state_t vbus_state;
  vbus_state_t next_vbus_state;

  sync2 #(
    .W(6)
  ) u_sync_pin (
    .clk(clk),
    .rst_n(rst_n),
    .d(port_power_sense_pin_in),
    .q(pin_s)
  );

  sync2 #(
    .W(6)
  ) u_sync_ss (
    .clk(clk),
    .rst_n(rst_n),
    .d(superspeed_power_sense_pin_in),
    .q(ss_pin_s)
  );

  sync2 #(
    .W(12)
  ) u_sync_misc (
    .clk(clk),
    .rst_n(rst_n),
    .d({cc_compare_in, vconn_in_range, bus_voltage_monitor_input_safe5v,
      bus_voltage_monitor_input_safe0v}),
    .q({cc_s, vin_s, safe5_s, safe0_s})
  );

  // split ports take superspeed power from their own register
  assign ss_eff = (split & ss_power) | (~split & power);

  genvar i;
  generate
    for (i = 0; i < ppoc_pkg::NPORTS; i++) begin : g_port
      oc_filter u_f (
        .clk(clk),
        .rst_n(rst_n),
        .powered(power[i] & pin_rel2[i]),
        .sense_low(!pin_s[i]),
        .length(filter_len),
        .fault(fault[i])
      );
      oc_filter u_fs (
        .clk(clk),
        .rst_n(rst_n),
        .powered(split[i] & ss_power[i] & ss_rel2[i]),
        .sense_low(!ss_pin_s[i]),
        .length(filter_len),
        .fault(ss_fault[i])
      );
    end
  endgenerate

  // a pin let go a moment ago still shows its old drive through the
  // synchroniser; a pin held low for charging is never sensed at all
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_rel1 <= 6'h00;
      pin_rel2 <= 6'h00;
      ss_rel1 <= 6'h00;
      ss_rel2 <= 6'h00;
    end else begin
      pin_rel1 <= port_power_sense_pin_oe_n;
      pin_rel2 <= pin_rel1;
      ss_rel1 <= superspeed_power_sense_pin_oe_n;
      ss_rel2 <= ss_rel1;
    end
  end

  // attach follows the bus voltage only as an upstream-facing port
  always_comb begin
    next_vbus_state = vbus_state;
    unique case (vbus_state)
      VBUS_DETACHED: begin
        if (ufp_mode && safe5_s) begin
          next_vbus_state = VBUS_ATTACHED;
        end
      end
      VBUS_ATTACHED: begin
        if (!ufp_mode || (safe0_s && !safe5_s)) begin
          next_vbus_state = VBUS_DETACHED;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vbus_state <= VBUS_DETACHED;
    end else begin
      vbus_state <= next_vbus_state;
    end
  end

  // registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power <= 6'h00;
      split <= ppoc_pkg::SPLIT_RESET[5:0];
      ss_power <= 6'h00;
      charge <= 6'h00;
      filter_len <= ppoc_pkg::FILTER_RESET;
      mask <= '0;
      cc_threshold_sel <= 3'h0;
      ufp_mode <= 1'b0;
      vconn_req <= 2'h0;
    end else if (wr) begin
      unique case (addr)
        ppoc_pkg::A_POWER: power <= wdata[5:0];
        ppoc_pkg::A_SPLIT: split <= wdata[5:0];
        ppoc_pkg::A_SS_POWER: ss_power <= wdata[5:0];
        ppoc_pkg::A_CHARGE: charge <= wdata[5:0];
        ppoc_pkg::A_FILTER: filter_len <= wdata;
        ppoc_pkg::A_MASK: mask <= wdata[ppoc_pkg::ST_W-1:0];
        ppoc_pkg::A_CC_SEL: cc_threshold_sel <= wdata[2:0];
        ppoc_pkg::A_TYPEC_CTL: begin
          vconn_req <= wdata[1:0];
          ufp_mode <= wdata[2];
        end
        default: ;
      endcase
    end
  end

  // edge events
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_d <= 6'h00;
      ss_fault_d <= 6'h00;
      cc_d <= 8'h00;
      safe5_d <= 1'b0;
    end else begin
      fault_d <= fault;
      ss_fault_d <= ss_fault;
      cc_d <= cc_s;
      safe5_d <= safe5_s;
    end
  end

  always_comb begin
    events = '0;
    events[5:0] = fault & ~fault_d;
    events[ppoc_pkg::ST_SS +: 6] = ss_fault & ~ss_fault_d;
    events[ppoc_pkg::ST_CC] = ufp_mode && (cc_s != cc_d);
    events[ppoc_pkg::ST_VCONN] = |(vconn_enable & ~vin_s);
    events[ppoc_pkg::ST_VBUS] = safe5_s != safe5_d;
  end

  // set wins over write-one-to-clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
    end else if (wr && addr == ppoc_pkg::A_STATUS) begin
      status <= (status & ~wdata[ppoc_pkg::ST_W-1:0]) | events;
    end else begin
      status <= status | events;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  // read port, data one cycle after strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      unique case (addr)
        ppoc_pkg::A_POWER: rdata <= {10'h000, power};
        ppoc_pkg::A_SPLIT: rdata <= {10'h000, split};
        ppoc_pkg::A_SS_POWER: rdata <= {10'h000, ss_power};
        ppoc_pkg::A_CHARGE: rdata <= {10'h000, charge};
        ppoc_pkg::A_FILTER: rdata <= filter_len;
        ppoc_pkg::A_STATUS: rdata <= {1'b0, status};
        ppoc_pkg::A_MASK: rdata <= {1'b0, mask};
        ppoc_pkg::A_CC_SEL: rdata <= {13'h0000, cc_threshold_sel};
        ppoc_pkg::A_TYPEC_CTL: rdata <= {13'h0000, ufp_mode, vconn_req};
        ppoc_pkg::A_LEVELS: rdata <= {cc_s, 2'h0, vin_s, safe5_s, safe0_s,
          fault[0], ss_fault[0]};
        default: rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

  // pins: low driver when off, open drain with pull-up when on.
  // charge indication drives low on a powered port only while sensing idle,
  // so it reuses the same pin without extra package pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_power_sense_pin_out <= 6'h00;
      port_power_sense_pin_oe_n <= 6'h00;
      port_power_sense_pull_up <= 6'h00;
      superspeed_power_sense_pin_out <= 6'h00;
      superspeed_power_sense_pin_oe_n <= 6'h00;
      superspeed_power_sense_pull_up <= 6'h00;
    end else begin
      port_power_sense_pin_out <= 6'h00;
      port_power_sense_pin_oe_n <= power & ~charge;
      port_power_sense_pull_up <= power;
      superspeed_power_sense_pin_out <= 6'h00;
      superspeed_power_sense_pin_oe_n <= split & ss_power;
      superspeed_power_sense_pull_up <= split & ss_power;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hs_power_on <= 6'h00;
      ss_power_on <= 6'h00;
      hs_overcurrent <= 6'h00;
      ss_overcurrent <= 6'h00;
      vconn_enable <= 2'h0;
      vbus_attached <= 1'b0;
    end else begin
      hs_power_on <= power;
      ss_power_on <= ss_eff;
      hs_overcurrent <= fault;
      ss_overcurrent <= (split & ss_fault) | (~split & fault);
      vconn_enable <= vconn_req & vin_s;
      vbus_attached <= next_vbus_state == VBUS_ATTACHED;
    end
  end
endmodule

// >>> ppoc_pkg.sv
package ppoc_pkg;
  localparam int NPORTS = 6;
  localparam int FILT_W = 16;
  // register indices
  localparam logic [7:0] A_POWER = 8'h00;
  localparam logic [7:0] A_SPLIT = 8'h01;
  localparam logic [7:0] A_SS_POWER = 8'h02;
  localparam logic [7:0] A_CHARGE = 8'h03;
  localparam logic [7:0] A_FILTER = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h05;
  localparam logic [7:0] A_MASK = 8'h06;
  localparam logic [7:0] A_CC_SEL = 8'h07;
  localparam logic [7:0] A_TYPEC_CTL = 8'h08;
  localparam logic [7:0] A_LEVELS = 8'h09;
  localparam logic [15:0] FILTER_RESET = 16'h0100;
  localparam logic [15:0] SPLIT_RESET = 16'h0000;
  // status layout: [5:0] port oc, [11:6] ss oc, 12 cc change, 13 vconn oc,
  // 14 vbus safe5v change
  localparam int ST_SS = 6;
  localparam int ST_CC = 12;
  localparam int ST_VCONN = 13;
  localparam int ST_VBUS = 14;
  localparam int ST_W = 15;
endpackage

// >>> oc_filter.sv
`timescale 1ns/1ns
module oc_filter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic powered,
  input wire logic sense_low,
  input wire logic [15:0] length,
  output logic fault
);
  logic [15:0] count;

  // counter restarts on any high, so a brief dip never reports
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 16'h0000;
      fault <= 1'b0;
    end else if (!powered || !sense_low) begin
      count <= 16'h0000;
      fault <= 1'b0;
    end else if (count >= length) begin
      fault <= 1'b1;
    end else begin
      count <= count + 16'h0001;
    end
  end
endmodule

// >>> sync2.sv
`timescale 1ns/1ns
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// >>> ppoc_asserts.sv
`timescale 1ns/1ns
module ppoc_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic wr,
  input wire logic [5:0] port_power_sense_pin_in,
  input wire logic [5:0] port_power_sense_pin_out,
  input wire logic [5:0] port_power_sense_pin_oe_n,
  input wire logic [5:0] port_power_sense_pull_up,
  input wire logic [5:0] superspeed_power_sense_pull_up,
  input wire logic [5:0] hs_power_on,
  input wire logic [5:0] ss_power_on,
  input wire logic [5:0] hs_overcurrent,
  input wire logic [5:0] ss_overcurrent
);
  logic split_seen;
  // sticky on purpose: split may be written back to zero later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) split_seen <= 1'b0;
    else if (wr && addr == ppoc_pkg::A_SPLIT) split_seen <= 1'b1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_off_low;
    (~hs_power_on & port_power_sense_pin_oe_n) == 6'h00 &&
      port_power_sense_pin_out == 6'h00;
  endproperty
  a_off_low: assert property (p_off_low) else $error("unpowered pin released");
  property p_off_no_pu;
    (~hs_power_on & port_power_sense_pull_up) == 6'h00;
  endproperty
  a_off_no_pu: assert property (p_off_no_pu) else $error("pull-up while off");
  property p_on_pu;
    (hs_power_on & ~port_power_sense_pull_up) == 6'h00;
  endproperty
  a_on_pu: assert property (p_on_pu) else $error("powered pin without pull-up");
  property p_filter;
    ((hs_overcurrent & ~$past(hs_overcurrent)) &
      ($past(port_power_sense_pin_in, 4) |
       $past(port_power_sense_pin_in, 5))) == 6'h00;
  endproperty
  a_filter: assert property (p_filter) else $error("fault without long low");
  property p_both_power;
    !split_seen |-> ss_power_on == hs_power_on;
  endproperty
  a_both_power: assert property (p_both_power) else $error("ss power differs");
  property p_both_oc;
    !split_seen |-> ss_overcurrent == hs_overcurrent;
  endproperty
  a_both_oc: assert property (p_both_oc) else $error("ss fault differs");
  property p_ss_pu;
    (superspeed_power_sense_pull_up & ~ss_power_on) == 6'h00;
  endproperty
  a_ss_pu: assert property (p_ss_pu) else $error("ss pull-up while off");
  property p_no_split;
    !split_seen |-> superspeed_power_sense_pull_up == 6'h00;
  endproperty
  a_no_split: assert property (p_no_split) else $error("ss pin live");
  c_hs_oc: cover property ($rose(hs_overcurrent[2]));
  c_ss_oc: cover property (split_seen && $rose(ss_overcurrent[3]));
  c_split: cover property ($rose(split_seen));
endmodule

// >>> ppoc_switch_model.sv
`timescale 1ns/1ns
module ppoc_switch_model (
  input wire logic clk,
  input wire logic [5:0] pin_out,
  input wire logic [5:0] oe_n,
  input wire logic [5:0] pull_up,
  input wire logic [5:0] fault,
  output logic [5:0] pin_in
);
  // released, unpulled line wanders rather than hold its level
  logic [5:0] last = 6'h00;
  always_ff @(posedge clk) begin
    last <= pin_in;
  end
  // driver wins; tripped switch or open fuse pulls low
  assign pin_in = (~oe_n & pin_out) |
    (oe_n & ~fault & (pull_up | ~last));
endmodule

// >>> port_power_overcurrent_ctl_tb_top.sv
`timescale 1ns/1ns
module port_power_overcurrent_ctl_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] cc_in = 8'h00;
  logic [1:0] vc_rng = 2'h0;
  logic safe5 = 1'b0;
  logic safe0 = 1'b1;
  logic [5:0] hs_f = 6'h00;
  logic [5:0] ss_f = 6'h00;
  logic [15:0] rdata;
  logic irq, vbus;
  logic [5:0] p_in, p_out, p_oe, p_pu, s_in, s_out, s_oe, s_pu;
  logic [5:0] hs_on, ss_on, hs_oc, ss_oc, p, c;
  logic [2:0] cc_sel;
  logic [1:0] vc_en;
  int n_mismatch = 0;
  int samples_checked = 0;
  always #4 clk = ~clk;
  port_power_overcurrent_ctl dut (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq),
    .port_power_sense_pin_in(p_in), .port_power_sense_pin_out(p_out),
    .port_power_sense_pin_oe_n(p_oe), .port_power_sense_pull_up(p_pu),
    .superspeed_power_sense_pin_in(s_in),
    .superspeed_power_sense_pin_out(s_out),
    .superspeed_power_sense_pin_oe_n(s_oe),
    .superspeed_power_sense_pull_up(s_pu),
    .hs_power_on(hs_on), .ss_power_on(ss_on), .hs_overcurrent(hs_oc),
    .ss_overcurrent(ss_oc), .cc_compare_in(cc_in),
    .cc_threshold_sel(cc_sel), .vconn_enable(vc_en),
    .vconn_in_range(vc_rng), .bus_voltage_monitor_input_safe5v(safe5),
    .bus_voltage_monitor_input_safe0v(safe0), .vbus_attached(vbus));
  ppoc_switch_model hs_sw (.clk(clk), .pin_out(p_out), .oe_n(p_oe),
    .pull_up(p_pu), .fault(hs_f), .pin_in(p_in));
  ppoc_switch_model ss_sw (.clk(clk), .pin_out(s_out), .oe_n(s_oe),
    .pull_up(s_pu), .fault(ss_f), .pin_in(s_in));
  function automatic logic [5:0] exp_oe(input logic [5:0] a, b);
    return a & ~b;
  endfunction
  task automatic chk(input logic [17:0] s, e, input string n);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e, "rdata");
  endtask
  task automatic stop_test();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(79));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(p_oe | p_pu, 6'h00, "reset pins");
    rreg(ppoc_pkg::A_FILTER, ppoc_pkg::FILTER_RESET);
    rreg(ppoc_pkg::A_SPLIT, ppoc_pkg::SPLIT_RESET);
    rreg(8'h0a, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      p = (i == 4) ? 6'h3f : 6'($urandom);
      c = (i == 4) ? 6'h00 : 6'($urandom);
      wreg(ppoc_pkg::A_POWER, {10'h000, p});
      wreg(ppoc_pkg::A_CHARGE, {10'h000, c});
      repeat (3) @(negedge clk);
      chk({hs_on, p_pu}, {p, p}, "power");
      chk(ss_on, p, "ss power");
      chk(p_oe, exp_oe(p, c), "oe_n");
    end
    wreg(ppoc_pkg::A_FILTER, 16'h0008);
    wreg(ppoc_pkg::A_MASK, 16'h0000);
    hs_f <= 6'h04;
    repeat (6) @(posedge clk);
    hs_f <= 6'h00;
    repeat (20) @(posedge clk);
    hs_f <= 6'h04;
    repeat (20) @(negedge clk);
    chk({hs_oc, ss_oc}, 12'h104, "oc");
    chk(irq, 1'b0, "masked irq");
    wreg(ppoc_pkg::A_MASK, 16'h0004);
    hs_f <= 6'h00;
    repeat (2) @(negedge clk);
    chk(irq, 1'b1, "irq");
    rreg(ppoc_pkg::A_STATUS, 16'h0004);
    wreg(ppoc_pkg::A_STATUS, 16'h7fff);
    rreg(ppoc_pkg::A_STATUS, 16'h0000);
    wreg(ppoc_pkg::A_POWER, 16'h0000);
    wreg(ppoc_pkg::A_SPLIT, 16'h0008);
    wreg(ppoc_pkg::A_SS_POWER, 16'h0008);
    ss_f <= 6'h08;
    repeat (20) @(negedge clk);
    chk({hs_on, ss_on, s_pu}, 18'h0_0208, "split pwr");
    chk({hs_oc, ss_oc}, 12'h008, "split oc");
    p = 6'($urandom);
    wreg(ppoc_pkg::A_CC_SEL, {13'h0000, p[2:0]});
    wreg(ppoc_pkg::A_TYPEC_CTL, 16'h0007);
    ss_f <= 6'h00;
    repeat (3) @(posedge clk);
    wreg(ppoc_pkg::A_STATUS, 16'h7fff);
    cc_in <= 8'h0f;
    vc_rng <= 2'h1;
    safe0 <= 1'b0;
    safe5 <= 1'b1;
    repeat (8) @(negedge clk);
    chk({cc_sel, vc_en, vbus}, {p[2:0], 3'h3}, "typec");
    rreg(ppoc_pkg::A_STATUS, 16'h5000);
    @(posedge clk);
    safe0 <= 1'b1;
    safe5 <= 1'b0;
    vc_rng <= 2'h0;
    repeat (8) @(negedge clk);
    chk(vbus, 1'b0, "detach");
    chk(vc_en, 2'h0, "vconn off");
    rreg(ppoc_pkg::A_STATUS, 16'h7000);
    stop_test();
  end
  initial begin
    #100000;
    n_mismatch++;
    stop_test();
  end
endmodule
bind port_power_overcurrent_ctl ppoc_asserts u_chk (.clk, .rst_n, .addr,
  .wr, .port_power_sense_pin_in, .port_power_sense_pin_out,
  .port_power_sense_pin_oe_n, .port_power_sense_pull_up,
  .superspeed_power_sense_pull_up, .hs_power_on, .ss_power_on,
  .hs_overcurrent, .ss_overcurrent);
